/* File: common/drt_pkg.sv */
package drt_pkg;

   // ****************************************
   // register select and write keys
   // ****************************************
   localparam logic [1:0] SEL_CONTROL_STATUS = 2'h0;
   localparam logic [1:0] SEL_INTERVAL_COUNT = 2'h1;
   localparam logic [1:0] SEL_INTERVAL_CONST = 2'h2;
   localparam logic [1:0] SEL_REFRESH_COUNT  = 2'h3;
   localparam logic [7:0] WRITE_KEY          = 8'hA5;
   localparam logic [5:0] REFRESH_COUNT_KEY  = 6'h29;

   // ****************************************
   // control/status field positions
   // ****************************************
   localparam int unsigned CS_CMF_BIT  = 7;
   localparam int unsigned CS_COMPARE_MATCH_IRQ_ENABLE_BIT = 6;
   localparam int unsigned CS_CKS_MSB  = 5;
   localparam int unsigned CS_CKS_LSB  = 3;
   localparam int unsigned CS_OVF_BIT  = 2;
   localparam int unsigned CS_COUNT_LIMIT_IRQ_ENABLE_BIT = 1;
   localparam int unsigned CS_COUNT_LIMIT_SELECT_BIT = 0;

   // ****************************************
   // reset values and limits
   // ****************************************
   localparam logic [7:0]  CONTROL_RESET   = 8'h00;
   localparam logic [7:0]  COUNTER_RESET   = 8'h00;
   localparam logic [7:0]  CONSTANT_RESET  = 8'h00;
   localparam logic [9:0]  REFRESH_RESET   = 10'h000;
   localparam logic [10:0] LIMIT_LONG      = 11'h400;
   localparam logic [10:0] LIMIT_SHORT     = 11'h200;
   localparam logic [2:0]  CLOCK_STOPPED   = 3'h0;

   // divider masks: a tick when the masked phase bits are all ones
   localparam logic [11:0] DIV_MASK [0:7] = '{12'h000, 12'h003, 12'h00F, 12'h03F,
                                              12'h0FF, 12'h3FF, 12'h7FF, 12'hFFF};

endpackage

/* File: common/drt_if.sv */
interface drt_if;
   logic [2:0] clock_select;
   logic       run;
   logic       tick;
   logic       refresh_done;
   logic       limit_select;
   logic       count_wr;
   logic [9:0] count_wdata;
   logic [9:0] count;
   logic       limit_hit;

   modport ctrl    (output clock_select, run, refresh_done, limit_select, count_wr,
                    count_wdata, input tick, count, limit_hit);
   modport presc   (input clock_select, run, output tick);
   modport counter (input refresh_done, limit_select, count_wr, count_wdata,
                    output count, limit_hit);
endinterface

/* File: core/drt_prescaler.sv */
module drt_prescaler (
   input  wire logic i_clock,
   input  wire logic i_rst_n,
   drt_if.presc      bus
);

   typedef struct packed {
      logic [11:0] phase;
      logic        tick;
   } drt_presc_state_type;

   drt_presc_state_type state_q;
   drt_presc_state_type state_d;

   // ****************************************
   // free-running phase, one tick per period
   // ****************************************
   always_comb begin
      state_d      = state_q;
      state_d.tick = 1'b0;
      if (bus.clock_select == drt_pkg::CLOCK_STOPPED) begin
         state_d.phase = 12'h000;
      end else if (bus.run) begin
         state_d.phase = state_q.phase + 12'h001;
         // all-ones test keeps the period exact for every ratio
         if ((state_q.phase & drt_pkg::DIV_MASK[bus.clock_select])
             == drt_pkg::DIV_MASK[bus.clock_select]) begin
            state_d.tick = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign bus.tick = state_q.tick;

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   a_tick_stopped: assert property (bus.clock_select == drt_pkg::CLOCK_STOPPED |=> !bus.tick)
      else $error("tick while clock input disabled");
   a_tick_spacing: assert property (bus.tick |=> !bus.tick [*3])
      else $error("ticks closer than four bus clocks");

endmodule

/* File: core/drt_refresh_count.sv */
module drt_refresh_count (
   input  wire logic i_clock,
   input  wire logic i_rst_n,
   drt_if.counter    bus
);

   typedef struct packed {
      logic [9:0] count;
      logic       limit_hit;
   } drt_rc_state_type;

   drt_rc_state_type state_q;
   drt_rc_state_type state_d;
   logic [10:0]      limit;

   // ****************************************
   // refresh count and limit check
   // ****************************************
   always_comb begin
      limit             = bus.limit_select ? drt_pkg::LIMIT_SHORT : drt_pkg::LIMIT_LONG;
      state_d           = state_q;
      state_d.limit_hit = 1'b0;
      if (bus.count_wr) begin
         state_d.count = bus.count_wdata;
      end else if (bus.refresh_done) begin
         // reaching the limit is passing it; also catches a count above a lowered limit
         if (({1'b0, state_q.count} + 11'h001) >= limit) begin
            state_d.count     = drt_pkg::REFRESH_RESET;
            state_d.limit_hit = 1'b1;
         end else begin
            state_d.count = state_q.count + 10'h001;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state_q <= '{count: drt_pkg::REFRESH_RESET, limit_hit: 1'b0};
      end else begin
         state_q <= state_d;
      end
   end

   assign bus.count     = state_q.count;
   assign bus.limit_hit = state_q.limit_hit;

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   a_limit_wrap: assert property (bus.refresh_done && !bus.count_wr && bus.limit_select
                                  && bus.count == 10'h1FF |=> bus.limit_hit && bus.count == 10'h000)
      else $error("short limit did not wrap the refresh count");

endmodule

/* File: core/drt_top.sv */
module drt_top (
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic [1:0]  i_reg_sel,
   input  wire logic        i_wr,
   input  wire logic        i_wr_word,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_standby,
   input  wire logic        i_refresh_enable,
   input  wire logic        i_refresh_mode,
   input  wire logic        i_refresh_done,
   output logic      [15:0] o_rdata,
   output logic             o_refresh_request,
   output logic             o_compare_irq,
   output logic             o_limit_irq
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic        compare_match_flag;
      logic        compare_match_irq_enable;
      logic [2:0]  cks;
      logic        ovf;
      logic        count_limit_irq_enable;
      logic        count_limit_select;
      logic        clear_armed;
      logic [7:0]  counter;
      logic [7:0]  constant;
      logic [15:0] rdata;
      logic        refresh_req;
      logic        cmi_irq;
      logic        ovi_irq;
   } drt_state_type;

   drt_state_type state_q;
   drt_state_type state_d;

   drt_if link ();

   logic wr_control;
   logic wr_counter;
   logic wr_constant;
   logic match;
   logic auto_refresh;
   logic count_tick;

   // ****************************************
   // keyed word write decode
   // ****************************************
   function automatic logic write_hits(input logic [1:0]  target,
                                       input logic [1:0]  sel,
                                       input logic        wr,
                                       input logic        word,
                                       input logic [15:0] wdata);
      logic key_ok;
      key_ok = 1'b0;
      if (target == drt_pkg::SEL_REFRESH_COUNT) begin
         key_ok = (wdata[15:10] == drt_pkg::REFRESH_COUNT_KEY);
      end else begin
         key_ok = (wdata[15:8] == drt_pkg::WRITE_KEY);
      end
      // byte writes and a wrong key leave the target untouched
      return wr && word && (sel == target) && key_ok;
   endfunction

   assign wr_control  = write_hits(drt_pkg::SEL_CONTROL_STATUS, i_reg_sel, i_wr, i_wr_word,
                                   i_wdata);
   assign wr_counter  = write_hits(drt_pkg::SEL_INTERVAL_COUNT, i_reg_sel, i_wr, i_wr_word,
                                   i_wdata);
   assign wr_constant = write_hits(drt_pkg::SEL_INTERVAL_CONST, i_reg_sel, i_wr, i_wr_word,
                                   i_wdata);

   // ****************************************
   // sub-blocks
   // ****************************************
   assign link.clock_select = state_q.cks;
   assign link.run          = !i_standby;
   assign link.refresh_done = i_refresh_done;
   assign link.limit_select = state_q.count_limit_select;
   assign link.count_wr     = write_hits(drt_pkg::SEL_REFRESH_COUNT, i_reg_sel, i_wr,
                                         i_wr_word, i_wdata);
   assign link.count_wdata  = i_wdata[9:0];

   drt_prescaler u_prescaler (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .bus     (link.presc)
   );

   drt_refresh_count u_refresh_count (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .bus     (link.counter)
   );

   // ****************************************
   // compare, flags and refresh request
   // ****************************************
   // a tick launched just before the clock select went to stop is dropped
   assign count_tick   = link.tick && (state_q.cks != drt_pkg::CLOCK_STOPPED);
   assign match        = count_tick && (state_q.counter == state_q.constant);
   assign auto_refresh = i_refresh_enable && !i_refresh_mode;

   always_comb begin
      state_d             = state_q;
      state_d.refresh_req = 1'b0;

      // interval counter: a software write beats a count in the same cycle
      if (wr_counter) begin
         state_d.counter = i_wdata[7:0];
      end else if (match) begin
         state_d.counter = drt_pkg::COUNTER_RESET;
      end else if (count_tick) begin
         state_d.counter = state_q.counter + 8'h01;
      end

      if (wr_constant) begin
         state_d.constant = i_wdata[7:0];
      end

      // clear before the write, so a zero written in this cycle re-arms
      if (state_q.clear_armed && i_refresh_done && auto_refresh) begin
         state_d.compare_match_flag         = 1'b0;
         state_d.clear_armed = 1'b0;
      end

      if (wr_control) begin
         state_d.compare_match_irq_enable = i_wdata[drt_pkg::CS_COMPARE_MATCH_IRQ_ENABLE_BIT];
         state_d.cks  = i_wdata[drt_pkg::CS_CKS_MSB:drt_pkg::CS_CKS_LSB];
         state_d.count_limit_irq_enable = i_wdata[drt_pkg::CS_COUNT_LIMIT_IRQ_ENABLE_BIT];
         state_d.count_limit_select = i_wdata[drt_pkg::CS_COUNT_LIMIT_SELECT_BIT];
         // writing zero only arms the clear; the refresh itself clears
         if (!i_wdata[drt_pkg::CS_CMF_BIT]) begin
            state_d.clear_armed = 1'b1;
         end
         if (!i_wdata[drt_pkg::CS_OVF_BIT]) begin
            state_d.ovf = 1'b0;
         end
      end

      // sets come last so an event in the clearing cycle is kept
      if (match) begin
         state_d.compare_match_flag         = 1'b1;
         state_d.refresh_req = auto_refresh;
      end
      if (link.limit_hit) begin
         state_d.ovf = 1'b1;
      end

      state_d.cmi_irq = state_d.compare_match_flag && state_d.compare_match_irq_enable;
      state_d.ovi_irq = state_d.ovf && state_d.count_limit_irq_enable;

      // ****************************************
      // word-wide read, undefined bits zero
      // ****************************************
      unique case (i_reg_sel)
         drt_pkg::SEL_CONTROL_STATUS: begin
            state_d.rdata = {8'h00, state_q.compare_match_flag, state_q.compare_match_irq_enable, state_q.cks, state_q.ovf,
                             state_q.count_limit_irq_enable, state_q.count_limit_select};
         end
         drt_pkg::SEL_INTERVAL_COUNT: begin
            state_d.rdata = {8'h00, state_q.counter};
         end
         drt_pkg::SEL_INTERVAL_CONST: begin
            state_d.rdata = {8'h00, state_q.constant};
         end
         drt_pkg::SEL_REFRESH_COUNT: begin
            state_d.rdata = {6'h00, link.count};
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         // only power-on reset clears; no other reset reaches these flops
         state_q          <= '0;
         state_q.cks      <= drt_pkg::CONTROL_RESET[drt_pkg::CS_CKS_MSB:drt_pkg::CS_CKS_LSB];
         state_q.counter  <= drt_pkg::COUNTER_RESET;
         state_q.constant <= drt_pkg::CONSTANT_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   assign o_rdata           = state_q.rdata;
   assign o_refresh_request = state_q.refresh_req;
   assign o_compare_irq     = state_q.cmi_irq;
   assign o_limit_irq       = state_q.ovi_irq;

   // ****************************************
   // checks
   // ****************************************
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   sequence s_zero_written;
      wr_control && !i_wdata[drt_pkg::CS_CMF_BIT];
   endsequence

   sequence s_auto_refresh_done;
      i_refresh_done && auto_refresh && !match;
   endsequence

   a_reset_clear: assert property (!$past(i_rst_n) |-> state_q.compare_match_flag == 1'b0
                                   && state_q.cks == 3'h0 && state_q.counter == 8'h00
                                   && state_q.constant == 8'h00)
      else $error("registers not zero after power-on reset");

   a_reserved_zero: assert property ($past(i_reg_sel) != drt_pkg::SEL_REFRESH_COUNT
                                     |-> o_rdata[15:8] == 8'h00)
      else $error("upper byte read as non-zero");

   a_match_flag: assert property (match && !wr_counter |=> state_q.compare_match_flag
                                  && state_q.counter == 8'h00)
      else $error("match did not set flag and clear counter");

   a_one_keeps_flag: assert property (state_q.compare_match_flag && !state_q.clear_armed && !i_refresh_done
                                      |=> state_q.compare_match_flag)
      else $error("compare flag dropped without armed refresh");

   a_armed_clear: assert property (s_zero_written ##1 s_auto_refresh_done
                                   |=> !state_q.compare_match_flag)
      else $error("armed refresh did not clear compare flag");

   a_cmi_gate: assert property (o_compare_irq == (state_q.compare_match_flag && state_q.compare_match_irq_enable))
      else $error("compare interrupt not gated by its enable");

   a_clock_stop: assert property (state_q.cks == 3'h0 && !wr_counter
                                  |=> $stable(state_q.counter))
      else $error("counter moved with clock input disabled");

   a_standby_hold: assert property (i_standby && !wr_counter ##1 i_standby && !wr_counter
                                    |=> $stable(state_q.counter))
      else $error("counter moved in standby");

   a_limit_flag: assert property (link.limit_hit |=> state_q.ovf)
      else $error("limit flag not set");

   a_limit_clear: assert property (wr_control && !i_wdata[drt_pkg::CS_OVF_BIT]
                                   && !link.limit_hit |=> !state_q.ovf)
      else $error("zero write did not clear limit flag");

   a_ovi_gate: assert property (o_limit_irq == (state_q.ovf && state_q.count_limit_irq_enable))
      else $error("limit interrupt not gated by its enable");

   a_refresh_req: assert property (match |=> o_refresh_request == $past(auto_refresh))
      else $error("refresh request does not follow match");

   a_bad_key: assert property (i_wr && i_wdata[15:8] != drt_pkg::WRITE_KEY
                               |=> $stable(state_q.constant) && $stable(state_q.cks))
      else $error("write with wrong key changed a register");

   a_byte_ignored: assert property (i_wr && !i_wr_word |=> $stable(state_q.constant))
      else $error("byte write changed a register");

   a_armed_refresh: assert property (state_q.clear_armed ##0 s_auto_refresh_done
                                     |=> !state_q.compare_match_flag)
      else $error("refresh with clear armed kept compare flag");

   a_count_step: assert property (count_tick && !match && !wr_counter
                                  |=> state_q.counter == $past(state_q.counter) + 8'h01)
      else $error("counter did not advance on tick");

   a_counter_write: assert property (wr_counter |=> state_q.counter == $past(i_wdata[7:0]))
      else $error("keyed counter write did not land");

   a_constant_write: assert property (wr_constant
                                      |=> state_q.constant == $past(i_wdata[7:0]))
      else $error("keyed constant write did not land");

   a_limit_keep: assert property (state_q.ovf && !(wr_control && !i_wdata[drt_pkg::CS_OVF_BIT])
                                  |=> state_q.ovf)
      else $error("limit flag dropped without zero write");

   a_standby_tick: assert property (i_standby |=> !link.tick)
      else $error("tick issued in standby");

   a_request_gate: assert property (!auto_refresh |=> !o_refresh_request)
      else $error("refresh request outside enabled auto mode");

   a_req_pulse: assert property (o_refresh_request |=> !o_refresh_request)
      else $error("refresh request longer than one cycle");

endmodule

/* File: verification/drt_mem_model.sv */
module drt_mem_model (
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   input  wire logic       i_request,
   input  wire logic       i_kick,
   input  wire logic [1:0] i_delay,
   output logic            o_done
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // refresh engine: answers at once or late
   // ****************************************
   logic [1:0] wait_q;
   logic       pend_q;
   always_ff @(posedge i_clock) begin
      o_done <= 1'b0;
      if (!i_rst_n) begin
         pend_q <= 1'b0;
         wait_q <= 2'h0;
      end else if (i_kick) begin
         o_done <= 1'b1;
      end else if (i_request && i_delay == 2'h0) begin
         o_done <= 1'b1;
      end else if (i_request) begin
         pend_q <= 1'b1;
         wait_q <= i_delay;
      end else if (pend_q) begin
         wait_q <= wait_q - 2'h1;
         if (wait_q <= 2'h1) begin
            o_done <= 1'b1;
            pend_q <= 1'b0;
         end
      end
   end
endmodule

/* File: verification/tb_dram_refresh_timer.sv */
module tb_dram_refresh_timer;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clock, i_rst_n, i_wr, i_wr_word, i_standby, en, mode, done, kick;
   logic [1:0]  sel, dly;
   logic [15:0] wdata, rdata;
   logic        req, cirq, lirq, compare_match_irq_enable;
   int          err_total, checks_done, cyc, last_req, period, req_cnt, base;
   logic [15:0] k;

   drt_top i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_sel(sel), .i_wr(i_wr),
      .i_wr_word(i_wr_word), .i_wdata(wdata), .i_standby(i_standby),
      .i_refresh_enable(en), .i_refresh_mode(mode), .i_refresh_done(done),
      .o_rdata(rdata), .o_refresh_request(req), .o_compare_irq(cirq), .o_limit_irq(lirq));
   drt_mem_model i_mem (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_request(req),
      .i_kick(kick), .i_delay(dly), .o_done(done));

   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end

   // ****************************************
   // helpers
   // ****************************************
   function automatic int div_of(input int s);
      return (s < 5) ? (1 << (2 * s)) : (1 << (s + 5));
   endfunction

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [1:0] s, input logic [15:0] d, input logic word);
      @(posedge i_clock) #1;
      sel = s;
      wdata = d;
      i_wr_word = word;
      i_wr = 1'b1;
      @(posedge i_clock) #1;
      i_wr = 1'b0;
   endtask

   task automatic rd(input logic [1:0] s, input logic [15:0] exp);
      @(posedge i_clock) #1;
      sel = s;
      repeat (2) @(posedge i_clock);
      #1 chk("rdata", exp, rdata);
   endtask

   task automatic pulse_done();
      @(posedge i_clock) #1;
      kick = 1'b1;
      @(posedge i_clock) #1;
      kick = 1'b0;
      repeat (2) @(posedge i_clock);
   endtask

   task automatic wait_req(input int target, input int lim);
      int n;
      n = 0;
      while (req_cnt < target && n < lim) begin
         @(posedge i_clock);
         n++;
      end
      if (req_cnt < target) begin
         err_total++;
         $display("BAD refresh_request expected %0d seen %0d", target, req_cnt);
      end
   endtask

   always @(posedge i_clock) begin
      cyc++;
      if (req === 1'b1) begin
         period = cyc - last_req;
         last_req = cyc;
         req_cnt++;
      end
      if (cyc == 60000) begin
         err_total++;
         $display("BAD timeout expected 0 seen %0d", cyc);
         end_sim();
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {i_rst_n, i_wr, i_wr_word, i_standby, en, mode, kick, sel, dly, wdata} = '0;
      void'($urandom(34));
      repeat (5) @(posedge i_clock);
      #1 i_rst_n = 1'b1;
      for (int r = 0; r < 4; r++) rd(r[1:0], 16'h0000);
      $display("test reset done");

      // wrong key and byte access must not land
      k = {8'($urandom_range(255, 0)), 8'h33};
      if (k[15:8] == 8'hA5) k[15:8] = 8'h5A;
      wr(2'h2, k, 1'b1);
      wr(2'h2, 16'hA533, 1'b0);
      rd(2'h2, 16'h0000);
      k = 16'($urandom_range(255, 0));
      wr(2'h2, {8'hA5, k[7:0]}, 1'b1);
      rd(2'h2, {8'h00, k[7:0]});
      wr(2'h1, 16'hA50A, 1'b1);
      rd(2'h1, 16'h000A);
      $display("test key done");

      // counter holds in standby, runs after
      wr(2'h2, 16'hA5FF, 1'b1);
      i_standby = 1'b1;
      wr(2'h0, 16'hA588, 1'b1);
      repeat (40) @(posedge i_clock);
      rd(2'h1, 16'h000A);
      i_standby = 1'b0;
      repeat (40) @(posedge i_clock);
      @(posedge i_clock) #1;
      sel = 2'h1;
      repeat (2) @(posedge i_clock);
      #1 checks_done++;
      if (rdata[7:0] <= 8'h0A || rdata[15:8] !== 8'h00) begin
         err_total++;
         $display("BAD counter expected above 0a seen %h", rdata);
      end
      $display("test standby done");

      // every divider: constant 0 gives one request per tick
      en = 1'b1;
      for (int s = 1; s < 8; s++) begin
         compare_match_irq_enable = 1'($urandom_range(1, 0));
         dly = 2'($urandom_range(2, 0));
         wr(2'h2, 16'hA500, 1'b1);
         wr(2'h1, 16'hA500, 1'b1);
         wr(2'h0, {8'hA5, 1'b1, compare_match_irq_enable, s[2:0], 3'b100}, 1'b1);
         base = req_cnt;
         wait_req(base + 3, div_of(s) * 4 + 20);
         chk("period", 16'(div_of(s)), 16'(period));
         rd(2'h0, {8'h00, 1'b1, compare_match_irq_enable, s[2:0], 3'b000});
         chk("compare_irq", {15'h0, compare_match_irq_enable}, {15'h0, cirq});
      end
      $display("test divider done");

      // other refresh mode: flag yes, request no
      mode = 1'b1;
      wr(2'h0, 16'hA588, 1'b1);
      base = req_cnt;
      repeat (40) @(posedge i_clock);
      chk("request_count", 16'(base), 16'(req_cnt));
      #1 {en, mode} = 2'b00;
      base = req_cnt;
      repeat (40) @(posedge i_clock);
      chk("request_count", 16'(base), 16'(req_cnt));
      #1 {en, mode} = 2'b11;
      wr(2'h0, 16'hA540, 1'b1);
      pulse_done();
      rd(2'h0, 16'h00C0);
      mode = 1'b0;
      pulse_done();
      rd(2'h0, 16'h0040);
      chk("compare_irq", 16'h0000, {15'h0, cirq});
      $display("test compare clear done");

      // refresh count limit for both settings
      for (int l = 0; l < 2; l++) begin
         wr(2'h0, {8'hA5, 7'h01, l[0]}, 1'b1);
         wr(2'h3, {6'h29, l[0] ? 10'd510 : 10'd1022}, 1'b1);
         pulse_done();
         rd(2'h0, {14'h0, 1'b1, l[0]});
         pulse_done();
         rd(2'h3, 16'h0000);
         rd(2'h0, {13'h0, 2'b11, l[0]});
         chk("limit_irq", 16'h0001, {15'h0, lirq});
         wr(2'h0, {8'hA5, 7'h02, l[0]}, 1'b1);
         rd(2'h0, {13'h0, 2'b10, l[0]});
         chk("limit_irq", 16'h0000, {15'h0, lirq});
         wr(2'h0, {8'hA5, 7'h00, l[0]}, 1'b1);
         rd(2'h0, {13'h0, 2'b00, l[0]});
      end
      $display("test limit done");
      end_sim();
   end
endmodule
